// ---- upd_pkg.sv ----
// Shared constants, register map and carrier types of the peripheral block
package upd_pkg;

    // ==================================================================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 50; // 20 MHz system clock
    localparam int unsigned IDLE_TIME_US = 3000; // Idle time to suspend
    localparam int unsigned CLKOFF_TIME_US = 2000; // Suspend to clocks off
    localparam int unsigned SUSP_MIN_US = 5000; // Least time in suspend
    localparam int unsigned WAKE_TIME_US = 5000; // Normal wake-up length
    localparam int unsigned FAST_WAKE_US = 100; // Wake-up with test pin
    localparam int unsigned RWAKE_K_US = 10000; // Remote wake K length
    // Cycle counts, rounded up to whole clocks
    localparam int unsigned IDLE_CYC =
        (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CLKOFF_CYC =
        (CLKOFF_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SUSP_MIN_CYC =
        (SUSP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CYC =
        (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAST_WAKE_CYC =
        (FAST_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RWAKE_K_CYC =
        (RWAKE_K_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W = 18; // Timer width, holds 10 ms

    // ==================================================================
    // Register byte offsets
    localparam logic [4:0] OFF_DMA_SETUP = 5'h00; // dma_setup_reg
    localparam logic [4:0] OFF_DMA_COUNT = 5'h04; // dma_byte_count
    localparam logic [4:0] OFF_DMA_STAT = 5'h08; // Remaining count, busy
    localparam logic [4:0] OFF_EVENT = 5'h0C; // peripheral_event_reg
    localparam logic [4:0] OFF_EVENT_MASK = 5'h10; // Event mask register
    localparam logic [4:0] OFF_HW_SETUP = 5'h14; // hw_setup_reg
    localparam logic [4:0] OFF_MODE = 5'h18; // operating_mode_reg
    localparam logic [4:0] OFF_UNLOCK = 5'h1C; // Write-protect release
    localparam logic [31:0] UNLOCK_KEY = 32'h0000_A5C3; // Arbitrary value

    // ==================================================================
    // Field positions
    localparam int unsigned EV_SUSPEND = 0; // suspend_flag
    localparam int unsigned EV_RESUME = 1; // Resume flag
    localparam int unsigned EV_EOT = 2; // End of transfer flag
    localparam int unsigned EV_BUS = 3; // bus_line_state, read only
    localparam int unsigned HW_CLOCK_RUN = 0; // clock_run
    localparam int unsigned HW_WAKE_CS = 1; // wake_on_select
    localparam int unsigned MODE_GO_SUSP = 0; // go_suspend
    localparam int unsigned STAT_BUSY = 16; // DMA active in status

    // ==================================================================
    // Reset values
    localparam logic [2:0] EVENT_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [1:0] HW_RST = 2'h1; // Clocks run after reset
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ==================================================================
    // Carrier types
    typedef struct packed {
        logic ep_in; // Endpoint is IN
        logic ep_iso; // Endpoint is isochronous
        logic short_packet_eot_enable;
        logic count_eot_enable;
        logic dma_run_enable;
    } upd_dma_setup_s;
    localparam upd_dma_setup_s DMA_SETUP_RST = '0;

    typedef struct packed {
        logic line_idle; // Bus idle, J state
        logic sof; // Start of frame seen
        logic vbus; // Bus power present
        logic k_state; // Host drives K
        logic eop; // End of packet on the bus
    } upd_usb_s;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SUSP_WAIT = 3'b001,
        ST_SUSP = 3'b010,
        ST_OSC_START = 3'b011,
        ST_WAKE = 3'b100
    } upd_pwr_e;

endpackage

// ---- upd_sync.sv ----
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module upd_sync
    import upd_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    input wire logic [W-1:0] rst_val_i,
    output logic [W-1:0] sync_o
);
    // First and second stage per bit
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            // Meta stage feeds only the second stage
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_i[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    // Bits not yet through both stages show their idle level
    logic [1:0] primed_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            primed_ff <= 2'b00;
        end else begin
            primed_ff <= {primed_ff[0], 1'b1};
        end
    end

    assign sync_o = primed_ff[1] ? sync_ff : rst_val_i;
endmodule

// ---- upd_top.sv ----
// DMA end-of-transfer and suspend/resume control of a USB peripheral
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module upd_top
    import upd_pkg::*;
#(
    parameter int unsigned P_IDLE_CYC = IDLE_CYC,
    parameter int unsigned P_CLKOFF_CYC = CLKOFF_CYC,
    parameter int unsigned P_SUSP_MIN_CYC = SUSP_MIN_CYC,
    parameter int unsigned P_WAKE_CYC = WAKE_CYC,
    parameter int unsigned P_RWAKE_K_CYC = RWAKE_K_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM register slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Fly-by DMA side, same clock
    input wire logic dma_byte_i,
    input wire logic short_pkt_i,
    input wire logic pkt_done_i,
    output logic dma_req_o,
    output logic eot_o,
    output logic irq_o,
    // USB bus state pins
    input wire upd_usb_s usb_i,
    output logic drive_k_o,
    // Wake pins
    input wire logic suspend_wake_pin_i,
    output logic suspend_wake_pin_o,
    output logic suspend_wake_pin_oe_o,
    input wire logic cs_n_i,
    input wire logic fast_wake_test_pin_i,
    // Clock generation control
    input wire logic osc_stable_i,
    output logic osc_en_o,
    output logic int_clk_en_o
);
    // ==================================================================
    // Pin synchronisers
    localparam int unsigned NS = 9; // Synchronised pin count
    logic [NS-1:0] pin_raw; // Raw pin group
    logic [NS-1:0] pin_rst; // Idle level of each pin
    logic [NS-1:0] pin_s; // Synchronised pins
    upd_usb_s usb_s; // Synchronised bus state
    logic wpin_s; // Wake pin level
    logic cs_n_s; // Chip select level
    logic fast_s; // Fast wake test pin
    logic osc_ok_s; // Oscillator stable

    assign pin_raw = {usb_i, suspend_wake_pin_i, cs_n_i,
                      fast_wake_test_pin_i, osc_stable_i};
    assign pin_rst = {5'h10, 1'b1, 1'b1, 1'b0, 1'b0};
    assign usb_s = pin_s[8:4];
    assign wpin_s = pin_s[3];
    assign cs_n_s = pin_s[2];
    assign fast_s = pin_s[1];
    assign osc_ok_s = pin_s[0];

    upd_sync #(.W(NS)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pin_raw),
        .rst_val_i(pin_rst),
        .sync_o(pin_s)
    );

    // ==================================================================
    // Register state
    upd_dma_setup_s setup_ff; // DMA setup register
    logic [15:0] count_reg_ff; // Programmed byte count
    logic [15:0] remain_ff; // Internal DMA counter
    logic active_ff; // DMA in progress
    logic short_seen_ff; // Short packet pending end
    logic [2:0] event_ff; // Sticky event flags
    logic [2:0] mask_ff; // Event interrupt enables
    logic [1:0] hw_ff; // Clock run, wake on select
    logic go_susp_ff; // go_suspend bit
    logic lock_ff; // Register write protection
    logic ack_ff; // Bus answer phase
    logic [31:0] rdata_ff; // Read data holding
    logic eot_ff; // End of transfer pulse
    upd_pwr_e state_ff; // Power state
    logic idle_done_ff; // Idle period already reported
    logic vbus_d_ff; // Previous bus power level

    // Bus access decode
    logic req; // Read or write pending
    logic wr_en; // Write takes effect now
    logic wr_ok; // Write allowed by lock
    logic go_fall; // go_suspend cleared by write
    logic dma_end; // Terminating condition
    logic cnt_zero_end; // Counter exhausted
    logic susp_evt; // Suspend condition found
    logic wake_src; // Any wake source active
    logic wake_start; // Wake sequence begins

    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_ff;
    assign wr_en = avs_write_i & ack_ff;
    assign wr_ok = wr_en & ~lock_ff;

    // One wait cycle, answer on the second edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Read mux, locked block reads as zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read_i & ~ack_ff) begin
            if (lock_ff) begin
                rdata_ff <= 32'h0000_0000;
            end else begin
                case (avs_address_i)
                    OFF_DMA_SETUP: rdata_ff <= {27'h0, setup_ff};
                    OFF_DMA_COUNT: rdata_ff <= {16'h0, count_reg_ff};
                    OFF_DMA_STAT: rdata_ff <= {15'h0, active_ff, remain_ff};
                    OFF_EVENT: rdata_ff <= {28'h0, usb_s.line_idle,
                                            event_ff};
                    OFF_EVENT_MASK: rdata_ff <= {29'h0, mask_ff};
                    OFF_HW_SETUP: rdata_ff <= {30'h0, hw_ff};
                    OFF_MODE: rdata_ff <= {31'h0, go_susp_ff};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign avs_readdata_o = rdata_ff;

    // ==================================================================
    // DMA end of transfer
    assign cnt_zero_end = active_ff & dma_byte_i
        & (remain_ff == 16'h0001)
        & (setup_ff.count_eot_enable
           | (setup_ff.short_packet_eot_enable & setup_ff.ep_in
              & ~setup_ff.ep_iso));
    assign dma_end = cnt_zero_end
        | (active_ff & short_seen_ff & pkt_done_i)
        | (active_ff & setup_ff.ep_iso & usb_s.eop);

    // Setup register; hardware clears run enable at the end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            setup_ff <= DMA_SETUP_RST;
        end else if (wr_ok & (avs_address_i == OFF_DMA_SETUP)) begin
            setup_ff <= avs_writedata_i[4:0];
        end else if (dma_end) begin
            setup_ff.dma_run_enable <= 1'b0;
        end
    end

    // Programmed byte count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg_ff <= COUNT_RST;
        end else if (wr_ok & (avs_address_i == OFF_DMA_COUNT)) begin
            count_reg_ff <= avs_writedata_i[15:0];
        end
    end

    // Counter load on run enable, decrement per byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remain_ff <= COUNT_RST;
            active_ff <= 1'b0;
        end else if (wr_ok & (avs_address_i == OFF_DMA_SETUP)) begin
            if (avs_writedata_i[0] & ~active_ff) begin
                remain_ff <= count_reg_ff;
                active_ff <= 1'b1;
            end else if (~avs_writedata_i[0] | dma_end) begin
                active_ff <= 1'b0;
            end
        end else if (dma_end) begin
            active_ff <= 1'b0;
            remain_ff <= remain_ff - 16'h0001;
        end else if (active_ff & dma_byte_i) begin
            remain_ff <= remain_ff - 16'h0001;
        end
    end

    // Short packet on bulk OUT waits for its last byte
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            short_seen_ff <= 1'b0;
        end else if (~active_ff | dma_end) begin
            short_seen_ff <= 1'b0;
        end else if (short_pkt_i & setup_ff.short_packet_eot_enable
                     & ~setup_ff.ep_in & ~setup_ff.ep_iso) begin
            short_seen_ff <= 1'b1;
        end
    end

    // End pulse; disable path never raises it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eot_ff <= 1'b0;
        end else begin
            eot_ff <= dma_end;
        end
    end
    assign eot_o = eot_ff;
    assign dma_req_o = active_ff;

    // ==================================================================
    // Suspend detection
    logic [TMR_W-1:0] idle_cnt_ff; // Idle time counter

    // Bus activity or a frame start restarts the idle count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_cnt_ff <= '0;
            idle_done_ff <= 1'b1;
            vbus_d_ff <= 1'b0;
        end else begin
            vbus_d_ff <= usb_s.vbus;
            if (~usb_s.line_idle | usb_s.sof) begin
                idle_cnt_ff <= '0;
                idle_done_ff <= 1'b0;
            end else if (~idle_done_ff) begin
                if (idle_cnt_ff == TMR_W'(P_IDLE_CYC - 1)) begin
                    idle_done_ff <= 1'b1;
                end
                idle_cnt_ff <= idle_cnt_ff + 1'b1;
            end
        end
    end

    assign susp_evt = (~idle_done_ff & usb_s.line_idle & ~usb_s.sof
                       & (idle_cnt_ff == TMR_W'(P_IDLE_CYC - 1)))
                      | (vbus_d_ff & ~usb_s.vbus);

    // Events: hardware set wins over a write-one clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_ff <= EVENT_RST;
        end else begin
            if (wr_ok & (avs_address_i == OFF_EVENT)) begin
                event_ff <= event_ff & ~avs_writedata_i[2:0];
            end
            if (susp_evt) begin
                event_ff[EV_SUSPEND] <= 1'b1;
            end
            if (wake_start) begin
                event_ff[EV_RESUME] <= 1'b1;
            end
            if (dma_end) begin
                event_ff[EV_EOT] <= 1'b1;
            end
        end
    end

    // Mask, hardware setup and mode registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_ff <= MASK_RST;
            hw_ff <= HW_RST;
            go_susp_ff <= 1'b0;
        end else if (wr_ok) begin
            case (avs_address_i)
                OFF_EVENT_MASK: mask_ff <= avs_writedata_i[2:0];
                OFF_HW_SETUP: hw_ff <= avs_writedata_i[1:0];
                OFF_MODE: go_susp_ff <= avs_writedata_i[MODE_GO_SUSP];
                default: mask_ff <= mask_ff;
            endcase
        end
    end

    assign go_fall = wr_ok & (avs_address_i == OFF_MODE)
                     & go_susp_ff & ~avs_writedata_i[MODE_GO_SUSP];
    assign irq_o = |(event_ff & mask_ff);

    // ==================================================================
    // Power state machine
    logic [TMR_W-1:0] st_cnt_ff; // State timer
    logic [TMR_W-1:0] k_cnt_ff; // Remote wake K timer

    assign wake_src = usb_s.k_state | ~wpin_s
                      | (~cs_n_s & hw_ff[HW_WAKE_CS]);
    assign wake_start = (state_ff == ST_SUSP) & (st_cnt_ff == '0)
                        & wake_src;

    // Suspend entry, wait, wake and return
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_RUN;
            st_cnt_ff <= '0;
        end else begin
            if (st_cnt_ff != '0) begin
                st_cnt_ff <= st_cnt_ff - 1'b1;
            end
            case (state_ff)
                ST_RUN: begin
                    if (go_fall) begin
                        state_ff <= ST_SUSP_WAIT;
                        st_cnt_ff <= TMR_W'(P_CLKOFF_CYC - 1);
                    end
                end
                ST_SUSP_WAIT: begin
                    if (st_cnt_ff == '0) begin
                        state_ff <= ST_SUSP;
                        st_cnt_ff <= TMR_W'(P_SUSP_MIN_CYC - 1);
                    end
                end
                ST_SUSP: begin
                    if (wake_start) begin
                        state_ff <= ST_OSC_START;
                        st_cnt_ff <= fast_s ? TMR_W'(FAST_WAKE_CYC - 1)
                                            : TMR_W'(P_WAKE_CYC - 1);
                    end
                end
                ST_OSC_START: begin
                    if (osc_ok_s) begin
                        state_ff <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (st_cnt_ff == '0) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    // Remote wake K lasts its own time from the wake start
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            k_cnt_ff <= '0;
        end else if (wake_start & usb_s.k_state == 1'b0) begin
            k_cnt_ff <= TMR_W'(P_RWAKE_K_CYC);
        end else if (k_cnt_ff != '0) begin
            k_cnt_ff <= k_cnt_ff - 1'b1;
        end
    end
    assign drive_k_o = (k_cnt_ff != '0);

    // Lock set on wake, released by the key write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_ff <= 1'b0;
        end else if (wake_start) begin
            lock_ff <= 1'b1;
        end else if (wr_en & (avs_address_i == OFF_UNLOCK)
                     & (avs_writedata_i == UNLOCK_KEY)) begin
            lock_ff <= 1'b0;
        end
    end

    // Pin high in suspend, driven low through wake
    assign suspend_wake_pin_oe_o = (state_ff != ST_RUN);
    assign suspend_wake_pin_o = (state_ff == ST_SUSP_WAIT)
                                | (state_ff == ST_SUSP);
    assign osc_en_o = (state_ff != ST_SUSP);
    assign int_clk_en_o = (state_ff == ST_WAKE) | (state_ff == ST_SUSP_WAIT)
                          | ((state_ff == ST_RUN) & hw_ff[HW_CLOCK_RUN]);
endmodule

// ---- upd_far.sv ----
// Far side model: fly-by DMA engine and oscillator
`timescale 1ns/1ps
module upd_far (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic osc_en_i,
    input wire logic stall_i,
    output logic byte_o,
    output logic stable_o
);
    logic byte_ff; // Byte strobe towards the block
    logic [2:0] warm_ff; // Oscillator warm-up count
    // One byte every other cycle while requested, random stalls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) byte_ff <= 1'b0;
        else byte_ff <= req_i && !byte_ff && !stall_i;
    end
    // Oscillator settles some cycles after enable, drops at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) warm_ff <= 3'h0;
        else if (!osc_en_i) warm_ff <= 3'h0;
        else if (warm_ff != 3'h7) warm_ff <= warm_ff + 3'h1;
    end
    assign byte_o = byte_ff;
    assign stable_o = (warm_ff == 3'h7);
endmodule

// ---- upd_top_props.sv ----
// Port checker of the DMA end and suspend control
`timescale 1ns/1ps
module upd_chk #(
    parameter int P_CLKOFF_CYC = 20,
    parameter int P_SUSP_MIN_CYC = 30,
    parameter int P_WAKE_CYC = 60,
    parameter int P_RWAKE_K_CYC = 80
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic dma_req_o,
    input wire logic eot_o,
    input wire logic drive_k_o,
    input wire logic suspend_wake_pin_o,
    input wire logic suspend_wake_pin_oe_o,
    input wire logic osc_stable_i,
    input wire logic osc_en_o,
    input wire logic int_clk_en_o
);
    // Tolerance windows around the timed spans
    localparam int OFF_LO = P_CLKOFF_CYC - 2;
    localparam int OFF_HI = P_CLKOFF_CYC + 3;
    localparam int SM = P_SUSP_MIN_CYC - 1;
    localparam int WK_LO = P_WAKE_CYC - 3;
    localparam int WK_HI = P_WAKE_CYC + 3;
    localparam int RK_LO = P_RWAKE_K_CYC - 3;
    localparam int RK_HI = P_RWAKE_K_CYC + 3;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==============================================================
    // Assertions
    bus_wait_a: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late");
    eot_pulse_a:
        assert property (eot_o |=> !eot_o) else $error("eot long");
    eot_stop_a:
        assert property (eot_o |-> !dma_req_o) else $error("dma on");
    pin_susp_a:
        assert property (suspend_wake_pin_oe_o && !osc_en_o |->
        suspend_wake_pin_o) else $error("pin low");
    clk_off_a:
        assert property ($rose(suspend_wake_pin_oe_o) |->
        ##[OFF_LO:OFF_HI] $fell(osc_en_o)) else $error("clk off");
    min_susp_a:
        assert property ($rose(osc_en_o) |-> !$past(osc_en_o, SM))
        else $error("short sleep");
    wake_pin_a:
        assert property ($rose(osc_en_o) |-> !suspend_wake_pin_o &&
        suspend_wake_pin_oe_o) else $error("pin high");
    clk_stable_a:
        assert property ($rose(int_clk_en_o) && suspend_wake_pin_oe_o
        |-> $past(osc_stable_i, 2)) else $error("clk early");
    wake_len_a:
        assert property ($rose(osc_en_o) |->
        ##[WK_LO:WK_HI] $fell(suspend_wake_pin_oe_o)) else $error("wake");
    k_len_a:
        assert property ($rose(drive_k_o) |->
        ##[RK_LO:RK_HI] $fell(drive_k_o)) else $error("k len");
    // Main scenarios
    eot_c: cover property (eot_o);
    kdrv_c: cover property ($rose(drive_k_o));
    sleep_c: cover property ($fell(osc_en_o));
endmodule
bind upd_top upd_chk #(.P_CLKOFF_CYC(P_CLKOFF_CYC),
    .P_SUSP_MIN_CYC(P_SUSP_MIN_CYC), .P_WAKE_CYC(P_WAKE_CYC),
    .P_RWAKE_K_CYC(P_RWAKE_K_CYC)) upd_chk_i (.clk_i, .rst_n_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .dma_req_o, .eot_o,
    .drive_k_o, .suspend_wake_pin_o, .suspend_wake_pin_oe_o,
    .osc_stable_i, .osc_en_o, .int_clk_en_o);

// ---- upd_top_bench.sv ----
// Self-checking bench of the DMA end and suspend control
`timescale 1ns/1ps
module upd_top_bench;
    import upd_pkg::*;
    localparam int IDL = 40; // Shortened idle span
    logic clk_i = 0, rst_n_i = 0, rd_i = 0, wr_i = 0, wt, req, eot, irq;
    logic shp = 0, pkd = 0, ext = 1, cs_n = 1, stall = 0, byt, stb;
    logic dk, pin_o, pin_oe, osc, ks;
    logic [4:0] adr = 0;
    logic [31:0] wd = 0, rd, rdata;
    logic [15:0] rnd = 16'hA84E;
    upd_usb_s usb = '{0, 0, 1, 0, 0};
    int num_errors = 0, cmp_count = 0, nb, ne;
    upd_top #(.P_IDLE_CYC(IDL), .P_CLKOFF_CYC(20), .P_SUSP_MIN_CYC(30),
        .P_WAKE_CYC(60), .P_RWAKE_K_CYC(80)) upd_top_i (.clk_i, .rst_n_i,
        .avs_address_i(adr), .avs_read_i(rd_i), .avs_write_i(wr_i),
        .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wt), .dma_byte_i(byt), .short_pkt_i(shp),
        .pkt_done_i(pkd), .dma_req_o(req), .eot_o(eot), .irq_o(irq),
        .usb_i(usb), .drive_k_o(dk),
        .suspend_wake_pin_i(pin_oe ? pin_o & ext : ext),
        .suspend_wake_pin_o(pin_o), .suspend_wake_pin_oe_o(pin_oe),
        .cs_n_i(cs_n), .fast_wake_test_pin_i(1'b0), .osc_stable_i(stb),
        .osc_en_o(osc), .int_clk_en_o());
    upd_far upd_far_i (.clk_i, .rst_n_i, .req_i(req), .osc_en_i(osc),
        .stall_i(stall), .byte_o(byt), .stable_o(stb));
    initial forever #25 clk_i = ~clk_i;
    // Sixteen-bit LFSR step for random stimulus
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Random source, byte and eot counters
    always @(posedge clk_i) begin
        rnd <= lfsr(rnd);
        stall <= rnd[0];
        if (byt && req) nb++;
        if (eot) ne++;
        if (dk) ks = 1'b1;
    end
    // Avalon-MM cycle, held until waitrequest low
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr_i <= w;
        rd_i <= !w;
        do @(posedge clk_i); while (wt !== 1'b0);
        rd = rdata;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // One DMA run: 0 count, 1 short packet, 2 end of packet, 3 abort
    task automatic dma(input logic [4:0] su, input int md);
        int n;
        n = md ? 200 : int'(rnd[2:0]) + 1;
        bus(1'b1, OFF_DMA_COUNT, 32'(n));
        nb = 0;
        ne = 0;
        bus(1'b1, OFF_DMA_SETUP, {27'h0, su});
        @(posedge clk_i);
        while (req && nb < 2) @(posedge clk_i);
        if (md == 1) begin
            shp <= 1'b1;
            @(posedge clk_i) shp <= 1'b0;
            pkd <= 1'b1;
            @(posedge clk_i) pkd <= 1'b0;
        end
        if (md == 2) begin
            usb.eop <= 1'b1;
            repeat (3) @(posedge clk_i);
            usb.eop <= 1'b0;
        end
        if (md == 3) bus(1'b1, OFF_DMA_SETUP, 32'h0);
        while (req) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        if (md == 0) chk(32'(nb), 32'(n));
        chk(32'(ne), {31'h0, md != 3});
        chk({31'h0, irq}, {31'h0, md != 3});
        rchk(OFF_EVENT, md == 3 ? 32'h0 : 32'h4);
        bus(1'b1, OFF_EVENT, 32'h4);
        $display("dma test %0d done", md);
    endtask
    // Idle, suspend and wake by K, wake pin or chip select
    task automatic susp(input int src);
        int cyc;
        usb.sof <= 1'b1;
        @(posedge clk_i) usb.sof <= 1'b0;
        usb.line_idle <= 1'b1;
        repeat (IDL + 10) @(posedge clk_i);
        rchk(OFF_EVENT, 32'h9);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFF_HW_SETUP, {30'h0, src == 2, 1'b0});
        bus(1'b1, OFF_EVENT, 32'h1);
        bus(1'b1, OFF_MODE, 32'h1);
        bus(1'b1, OFF_MODE, 32'h0);
        while (osc) @(posedge clk_i);
        ks = 1'b0;
        cyc = 0;
        if (src == 0) usb.k_state <= 1'b1;
        if (src == 1) ext <= 1'b0;
        if (src == 2) cs_n <= 1'b0;
        while (!osc) begin
            @(posedge clk_i);
            cyc++;
        end
        chk({31'h0, cyc >= 30}, 32'h1);
        usb <= '{0, 0, 1, 0, 0};
        ext <= 1'b1;
        cs_n <= 1'b1;
        while (pin_oe) @(posedge clk_i);
        chk({31'h0, ks}, {31'h0, src != 0});
        rchk(OFF_EVENT, 32'h0);
        bus(1'b1, OFF_UNLOCK, UNLOCK_KEY);
        rchk(OFF_EVENT, 32'h2);
        bus(1'b1, OFF_EVENT, 32'h7);
        bus(1'b1, OFF_HW_SETUP, 32'h1);
        $display("wake test %0d done", src);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rchk(OFF_HW_SETUP, 32'h1);
        rchk(OFF_EVENT, 32'h0);
        rchk(5'h02, 32'h0);
        bus(1'b1, OFF_EVENT_MASK, 32'h7);
        dma(5'h03, 0);
        dma(5'h15, 0);
        dma(5'h05, 1);
        dma(5'h09, 2);
        dma(5'h1B, 0);
        dma(5'h03, 3);
        for (int s = 0; s < 3; s++) susp(s);
        // Loss of bus power alone reports suspend
        usb.vbus <= 1'b0;
        repeat (4) @(posedge clk_i);
        rchk(OFF_EVENT, 32'h1);
        $display("vbus test done");
        wrap_up();
    end
endmodule
